// File: design/tx_ramp_pkg.sv
package tx_ramp_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS    = 50;
    localparam int SYMBOL_NS        = 16000;
    localparam int LEAD_STEP_NS     = 2000;
    localparam int GAIN_STEP_NS     = 1000;
    localparam int CNT_W            = 10;
    localparam int SYMBOL_CYCLES    = SYMBOL_NS / CLK_PERIOD_NS;
    localparam int LEAD_STEP_CYCLES = LEAD_STEP_NS / CLK_PERIOD_NS;
    localparam int GAIN_STEP_CYCLES = GAIN_STEP_NS / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] SYMBOL_CNT    = CNT_W'(SYMBOL_CYCLES);
    localparam logic [CNT_W-1:0] GAIN_STEP_CNT = CNT_W'(GAIN_STEP_CYCLES);

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [5:0] ADDR_TX_POWER     = 6'h05;
    localparam logic [5:0] ADDR_TX_PATH      = 6'h16;
    localparam logic [7:0] TX_POWER_RESET    = 8'h60;
    localparam logic [7:0] TX_PATH_RESET     = 8'h31;
    localparam int         BOOST_BIT         = 7;
    localparam int         BIAS_GAIN_LSB     = 5;
    localparam int         LEAD_LSB          = 6;
    localparam int         OFFSET_LSB        = 0;
    localparam logic [6:0] MAX_POWER_WORD    = 7'h1F;

    typedef struct packed {
        logic       amp_high_power;
        logic [1:0] amp_bias_gain;
        logic [4:0] power_reduction_word;
    } power_cfg_t;

    typedef struct packed {
        logic [1:0] amp_lead_time;
        logic [3:0] spare;
        logic [1:0] power_word_offset;
    } path_cfg_t;

    typedef struct packed {
        logic       synth_tx_en;
        logic       amp_en;
        logic [1:0] amp_gain;
        logic       mod_en;
    } amp_ctrl_t;

    // ==========================================================
    // States and commands
    // ==========================================================
    typedef enum logic [3:0] {
        RADIO_IDLE    = 4'b0001,
        RADIO_LOCKED  = 4'b0010,
        RADIO_ARET    = 4'b0100,
        RADIO_BUSY_TX = 4'b1000
    } radio_state_t;

    typedef enum logic [4:0] {
        SEQ_IDLE   = 5'b00001,
        SEQ_LEAD   = 5'b00010,
        SEQ_DATA   = 5'b00100,
        SEQ_DOWN   = 5'b01000,
        SEQ_STAGES = 5'b10000
    } seq_state_t;

    typedef enum logic [1:0] {
        CMD_GO_IDLE = 2'h0,
        CMD_LOCK    = 2'h1,
        CMD_ARET    = 2'h2,
        CMD_TX_GO   = 2'h3
    } radio_cmd_t;

    // Lead time code to cycles: 2, 4, 6, 8 us
    function automatic logic [CNT_W-1:0] lead_cycles(input logic [1:0] code);
        lead_cycles = CNT_W'((int'(code) + 1) * LEAD_STEP_CYCLES);
    endfunction

    // Offset code 0..3 means -1..+2 on the word, clamped to the field
    function automatic logic [4:0] eff_power(input logic [4:0] word,
                                             input logic [1:0] offs);
        logic [6:0] sum;
        sum = {2'h0, word} + {5'h00, offs};
        if (sum == 7'h00) begin
            eff_power = 5'h00;
        end else if (sum - 7'h01 > MAX_POWER_WORD) begin
            eff_power = 5'h1F;
        end else begin
            eff_power = 5'(sum - 7'h01);
        end
    endfunction

endpackage

// File: design/pin_rise_sync.sv
`timescale 1ns/1ps
module pin_rise_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_async,
    output logic      rise
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign rise = sync_r & ~prev_r;

endmodule

// File: design/tx_power_ramp_control.sv
`timescale 1ns/1ps
module tx_power_ramp_control (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     sleep_transmit_pin,
    input  wire logic                     basic_mode,
    input  wire logic                     cmd_valid,
    input  wire tx_ramp_pkg::radio_cmd_t  cmd_code,
    input  wire logic                     frame_end,
    input  wire logic                     fe_route_en,
    input  wire logic [5:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_wdata,
    output logic [7:0]                    reg_rdata,
    output tx_ramp_pkg::radio_state_t     radio_state,
    output tx_ramp_pkg::amp_ctrl_t        amp_ctrl,
    output logic                          payload_start,
    output logic                          front_end_ctrl_pin,
    output logic [4:0]                    tx_power_word,
    output logic                          amp_high_power
);
    localparam logic [tx_ramp_pkg::CNT_W-1:0] CNT_ONE = 1;

    // ==========================================================
    // Registers
    // ==========================================================
    tx_ramp_pkg::power_cfg_t   power_r;
    tx_ramp_pkg::path_cfg_t    path_r;
    logic [1:0]                lead_eff_r;
    tx_ramp_pkg::radio_state_t radio_r;
    tx_ramp_pkg::seq_state_t   seq_r;
    tx_ramp_pkg::seq_state_t   seq_nxt;
    logic [tx_ramp_pkg::CNT_W-1:0] cnt_r;
    logic [tx_ramp_pkg::CNT_W-1:0] step_r;
    tx_ramp_pkg::amp_ctrl_t    ctrl_r;
    tx_ramp_pkg::amp_ctrl_t    ctrl_nxt;
    logic                      payload_r;

    wire logic pin_rise;

    pin_rise_sync u_pin_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_async (sleep_transmit_pin),
        .rise      (pin_rise)
    );

    wire logic wr_power = reg_wr && reg_addr == tx_ramp_pkg::ADDR_TX_POWER;
    wire logic wr_path  = reg_wr && reg_addr == tx_ramp_pkg::ADDR_TX_PATH;
    wire logic [7:0] rd_mux =
        (reg_addr == tx_ramp_pkg::ADDR_TX_POWER) ? power_r :
        (reg_addr == tx_ramp_pkg::ADDR_TX_PATH)  ? path_r  : 8'h00;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_r   <= tx_ramp_pkg::TX_POWER_RESET;
            path_r    <= tx_ramp_pkg::TX_PATH_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (wr_power) begin
                power_r <= reg_wdata;
            end
            if (wr_path) begin
                path_r <= reg_wdata;
            end
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Radio state and start decision
    // ==========================================================
    wire logic go_cmd   = cmd_valid && cmd_code == tx_ramp_pkg::CMD_TX_GO;
    wire logic seq_idle = seq_r == tx_ramp_pkg::SEQ_IDLE;
    // A pin edge and a command together are one trigger
    wire logic start_w  = (pin_rise || go_cmd) && seq_idle && basic_mode
                          && radio_r == tx_ramp_pkg::RADIO_LOCKED;
    wire logic lead_open = radio_r != tx_ramp_pkg::RADIO_BUSY_TX;
    wire logic tx_done  = seq_r == tx_ramp_pkg::SEQ_STAGES
                          && step_r == tx_ramp_pkg::GAIN_STEP_CNT - CNT_ONE;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            radio_r    <= tx_ramp_pkg::RADIO_IDLE;
            lead_eff_r <= 2'h0;
        end else begin
            if (start_w) begin
                radio_r <= tx_ramp_pkg::RADIO_BUSY_TX;
            end else if (tx_done) begin
                radio_r <= tx_ramp_pkg::RADIO_LOCKED;
            end else if (cmd_valid && seq_idle) begin
                case (cmd_code)
                    tx_ramp_pkg::CMD_GO_IDLE: radio_r <= tx_ramp_pkg::RADIO_IDLE;
                    tx_ramp_pkg::CMD_LOCK:    radio_r <= tx_ramp_pkg::RADIO_LOCKED;
                    tx_ramp_pkg::CMD_ARET:    radio_r <= tx_ramp_pkg::RADIO_ARET;
                    default:                  radio_r <= radio_r;
                endcase
            end
            // Freeze the lead time while a frame is going out
            if (lead_open) begin
                lead_eff_r <= path_r.amp_lead_time;
            end
        end
    end

    // ==========================================================
    // Ramp sequencer
    // ==========================================================
    wire logic [tx_ramp_pkg::CNT_W-1:0] amp_on_at =
        tx_ramp_pkg::SYMBOL_CNT - tx_ramp_pkg::lead_cycles(lead_eff_r) - CNT_ONE;
    wire logic step_done = step_r == tx_ramp_pkg::GAIN_STEP_CNT - CNT_ONE;
    wire logic [1:0] gain_target = power_r.amp_bias_gain;

    always_comb begin
        seq_nxt  = seq_r;
        ctrl_nxt = ctrl_r;
        case (seq_r)
            tx_ramp_pkg::SEQ_IDLE: begin
                if (start_w) begin
                    seq_nxt              = tx_ramp_pkg::SEQ_LEAD;
                    ctrl_nxt.synth_tx_en = 1'b1;
                end
            end
            tx_ramp_pkg::SEQ_LEAD: begin
                if (cnt_r == amp_on_at) begin
                    ctrl_nxt.amp_en   = 1'b1;
                    ctrl_nxt.amp_gain = 2'h0;
                end
                if (cnt_r == tx_ramp_pkg::SYMBOL_CNT - CNT_ONE) begin
                    seq_nxt         = tx_ramp_pkg::SEQ_DATA;
                    ctrl_nxt.mod_en = 1'b1;
                end
            end
            tx_ramp_pkg::SEQ_DATA: begin
                if (frame_end) begin
                    seq_nxt         = tx_ramp_pkg::SEQ_DOWN;
                    ctrl_nxt.mod_en = 1'b0;
                end
            end
            tx_ramp_pkg::SEQ_DOWN: begin
                if (step_done && ctrl_r.amp_gain != 2'h0) begin
                    ctrl_nxt.amp_gain = ctrl_r.amp_gain - 2'h1;
                end else if (step_done) begin
                    ctrl_nxt.amp_en = 1'b0;
                    seq_nxt         = tx_ramp_pkg::SEQ_STAGES;
                end
            end
            tx_ramp_pkg::SEQ_STAGES: begin
                if (step_done) begin
                    ctrl_nxt.synth_tx_en = 1'b0;
                    seq_nxt              = tx_ramp_pkg::SEQ_IDLE;
                end
            end
            default: begin
                seq_nxt  = tx_ramp_pkg::SEQ_IDLE;
                ctrl_nxt = '0;
            end
        endcase
        // Gain climbs one code per step while the amp is up and not ramping down
        if (ctrl_r.amp_en && (seq_r == tx_ramp_pkg::SEQ_LEAD || seq_r == tx_ramp_pkg::SEQ_DATA)
            && step_done && ctrl_r.amp_gain < gain_target) begin
            ctrl_nxt.amp_gain = ctrl_r.amp_gain + 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_r     <= tx_ramp_pkg::SEQ_IDLE;
            ctrl_r    <= '0;
            cnt_r     <= '0;
            step_r    <= '0;
            payload_r <= 1'b0;
        end else begin
            seq_r     <= seq_nxt;
            ctrl_r    <= ctrl_nxt;
            cnt_r     <= (seq_r == tx_ramp_pkg::SEQ_LEAD) ? cnt_r + CNT_ONE : '0;
            step_r    <= (step_done || seq_r != seq_nxt) ? '0 : step_r + CNT_ONE;
            payload_r <= seq_r == tx_ramp_pkg::SEQ_LEAD
                         && seq_nxt == tx_ramp_pkg::SEQ_DATA;
        end
    end

    // ==========================================================
    // Power word and outputs
    // ==========================================================
    logic [4:0] pwr_word_r;
    logic       boost_r;
    logic       fe_pin_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr_word_r <= 5'h00;
            boost_r    <= 1'b0;
            fe_pin_r   <= 1'b0;
        end else begin
            // Attenuation word, 1 dB per code; software keeps it at 13 or below
            pwr_word_r <= tx_ramp_pkg::eff_power(power_r.power_reduction_word,
                                                 path_r.power_word_offset);
            boost_r    <= power_r.amp_high_power;
            fe_pin_r   <= fe_route_en & ctrl_nxt.amp_en;
        end
    end

    assign tx_power_word      = pwr_word_r;
    assign amp_high_power     = boost_r;
    assign front_end_ctrl_pin = fe_pin_r;
    assign radio_state        = radio_r;
    assign amp_ctrl           = ctrl_r;
    assign payload_start      = payload_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    logic [tx_ramp_pkg::CNT_W-1:0] since_r;
    logic [tx_ramp_pkg::CNT_W-1:0] amp_age_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            since_r   <= '0;
            amp_age_r <= '0;
        end else begin
            since_r   <= start_w ? '0 : since_r + CNT_ONE;
            amp_age_r <= ctrl_r.amp_en ? amp_age_r + CNT_ONE : '0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_start_busy: assert property (start_w |=> radio_r == tx_ramp_pkg::RADIO_BUSY_TX)
        else $error("start did not enter transmit state");
    chk_payload_delay: assert property (payload_r |-> since_r == tx_ramp_pkg::SYMBOL_CNT)
        else $error("payload start not one symbol after start");
    chk_amp_lead: assert property (
        payload_r |-> amp_age_r == tx_ramp_pkg::lead_cycles(lead_eff_r))
        else $error("amp lead time wrong");
    chk_gain_floor: assert property ($rose(ctrl_r.amp_en) |-> ctrl_r.amp_gain == 2'h0)
        else $error("amp enabled above lowest gain");
    chk_down_order: assert property (
        $fell(ctrl_r.amp_en) |-> ctrl_r.synth_tx_en && !ctrl_r.mod_en && ctrl_r.amp_gain == 2'h0)
        else $error("stages switched off out of order");
    chk_lead_frozen: assert property (radio_r == tx_ramp_pkg::RADIO_BUSY_TX |=> $stable(lead_eff_r))
        else $error("lead time changed during transmit");
    chk_fe_follow: assert property (##1 front_end_ctrl_pin == ($past(fe_route_en) && ctrl_r.amp_en))
        else $error("front end pin mismatch");
    chk_power_sum: assert property (
        wr_path && reg_wdata[1:0] == 2'h0 ##1 (power_r.power_reduction_word == 5'h03 && !wr_power)
        |=> tx_power_word == 5'h02)
        else $error("offset not applied");
    chk_boost_bit: assert property (wr_power |=> ##1 amp_high_power == $past(reg_wdata[7], 2))
        else $error("boost bit not passed on");
    chk_start_locked: assert property ($rose(ctrl_r.synth_tx_en) |-> $past(radio_r) == tx_ramp_pkg::RADIO_LOCKED && $past(basic_mode))
        else $error("start outside locked basic mode");
    chk_single_start: assert property (start_w |=> !start_w [*8])
        else $error("second start during transmit");

    cov_pin_start: cover property (pin_rise && start_w);
    cov_full_frame: cover property (tx_done);
    cov_max_gain: cover property (ctrl_r.amp_gain == 2'h3 && ctrl_r.mod_en);
    cov_both_triggers: cover property (pin_rise && go_cmd && start_w);

endmodule

// File: testbench/host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: register port, commands and transmit pin
// ==========================================================
module host_model (
    input  wire logic               core_clk,
    input  wire logic [7:0]         reg_rdata,
    output logic [5:0]              reg_addr,
    output logic                    reg_wr,
    output logic                    reg_rd,
    output logic [7:0]              reg_wdata,
    output logic                    cmd_valid,
    output tx_ramp_pkg::radio_cmd_t cmd_code,
    output logic                    sleep_transmit_pin
);
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        cmd_valid = 1'b0;
        cmd_code = tx_ramp_pkg::CMD_GO_IDLE;
        sleep_transmit_pin = 1'b0;
    end

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        // Stale data never left looking valid
        reg_wdata = ~d;
    endtask

    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    task automatic send_cmd(input tx_ramp_pkg::radio_cmd_t c);
        @(negedge core_clk);
        cmd_code = c;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask

    // Callers bring the radio to locked first
    task automatic pin_rise();
        @(negedge core_clk);
        sleep_transmit_pin = 1'b1;
        @(negedge core_clk);
        @(negedge core_clk);
        sleep_transmit_pin = 1'b0;
    endtask
endmodule

// File: testbench/tx_power_ramp_control_tb_top.sv
`timescale 1ns/1ps
module tx_power_ramp_control_tb_top;
    localparam int S = tx_ramp_pkg::SYMBOL_CYCLES;
    localparam int G = tx_ramp_pkg::GAIN_STEP_CYCLES;
    logic                       core_clk;
    logic                       rst;
    logic                       basic_mode;
    logic                       frame_end;
    logic                       fe_route_en;
    logic [5:0]                 reg_addr;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [7:0]                 reg_wdata;
    logic [7:0]                 reg_rdata;
    logic                       cmd_valid;
    tx_ramp_pkg::radio_cmd_t    cmd_code;
    logic                       sleep_transmit_pin;
    tx_ramp_pkg::radio_state_t  radio_state;
    tx_ramp_pkg::amp_ctrl_t     amp_ctrl;
    logic                       payload_start;
    logic                       front_end_ctrl_pin;
    logic [4:0]                 tx_power_word;
    logic                       amp_high_power;
    logic [1:0]                 gain_tgt;
    logic [7:0]                 d;
    int                         errors = 0;
    int                         checked = 0;
    int                         cyc = 0;
    logic [4:0] pw_w [7] = '{5'h03, 5'h05, 5'h05, 5'h05, 5'h00, 5'h1F, 5'h0D};
    logic [1:0] pw_o [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1};
    logic [4:0] pw_e [7] = '{5'h02, 5'h05, 5'h06, 5'h07, 5'h00, 5'h1F, 5'h0D};

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc <= cyc + 1;

    host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .sleep_transmit_pin(sleep_transmit_pin));

    tx_power_ramp_control dut (.core_clk(core_clk), .rst(rst),
        .sleep_transmit_pin(sleep_transmit_pin), .basic_mode(basic_mode),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .frame_end(frame_end),
        .fe_route_en(fe_route_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .radio_state(radio_state),
        .amp_ctrl(amp_ctrl), .payload_start(payload_start),
        .front_end_ctrl_pin(front_end_ctrl_pin), .tx_power_word(tx_power_word),
        .amp_high_power(amp_high_power));

    // ==========================================================
    // Checking and waiting
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic bit cond(input int sel);
        case (sel)
            0: cond = (amp_ctrl.synth_tx_en === 1'b1);
            1: cond = (amp_ctrl.amp_en === 1'b1);
            2: cond = (payload_start === 1'b1);
            3: cond = (amp_ctrl.amp_gain === gain_tgt);
            4: cond = (amp_ctrl.mod_en === 1'b0);
            5: cond = (amp_ctrl.amp_en === 1'b0);
            default: cond = (amp_ctrl.synth_tx_en === 1'b0);
        endcase
    endfunction

    // Cycle stamp taken from a free counter, so host calls in between do not skew it
    task automatic wait_cond(input int sel, output int t);
        int n;
        n = 0;
        while (!cond(sel)) begin
            if (n >= 5000) begin
                $display("timeout on wait %0d", sel);
                errors++;
                finish_test();
            end
            @(negedge core_clk);
            n++;
        end
        t = cyc;
    endtask

    // ==========================================================
    // One whole transmission
    // ==========================================================
    task automatic run_tx(input logic [1:0] code, input logic [1:0] g);
        int t_syn, t_amp, t_gain, t_pay, t_mod, t_off, t_end, lead;
        lead = (int'(code) + 1) * tx_ramp_pkg::LEAD_STEP_CYCLES;
        gain_tgt = g;
        fe_route_en = code[1];
        host.wr_reg(tx_ramp_pkg::ADDR_TX_PATH, {code, 4'hC, 2'h1});
        host.wr_reg(tx_ramp_pkg::ADDR_TX_POWER, {1'b0, g, 5'h03});
        // Pin edge and go command meet at one sampling edge
        if (code == 2'h3) begin
            fork
                host.pin_rise();
                begin
                    repeat (2) @(negedge core_clk);
                    host.send_cmd(tx_ramp_pkg::CMD_TX_GO);
                end
            join
        end else if (code[0]) begin
            host.pin_rise();
        end else begin
            host.send_cmd(tx_ramp_pkg::CMD_TX_GO);
        end
        wait_cond(0, t_syn);
        check(radio_state, tx_ramp_pkg::RADIO_BUSY_TX);
        // Lead change while busy must not move this frame
        host.wr_reg(tx_ramp_pkg::ADDR_TX_PATH, {~code, 4'hC, 2'h1});
        wait_cond(1, t_amp);
        check(t_amp - t_syn, S - lead);
        check(amp_ctrl.amp_gain, 2'h0);
        check(front_end_ctrl_pin, code[1]);
        wait_cond(3, t_gain);
        check(t_gain - t_amp, int'(g) * G);
        wait_cond(2, t_pay);
        check(t_pay - t_amp, lead);
        check(t_pay - t_syn, S);
        host.send_cmd(tx_ramp_pkg::CMD_TX_GO);
        host.send_cmd(tx_ramp_pkg::CMD_GO_IDLE);
        @(negedge core_clk);
        frame_end = 1'b1;
        @(negedge core_clk);
        frame_end = 1'b0;
        wait_cond(4, t_mod);
        wait_cond(5, t_off);
        check(t_off - t_mod, (int'(g) + 1) * G);
        wait_cond(6, t_end);
        check(t_end - t_off, G);
        check(radio_state, tx_ramp_pkg::RADIO_LOCKED);
        repeat (40) @(negedge core_clk);
        check(amp_ctrl.synth_tx_en, 1'b0);
        check(radio_state, tx_ramp_pkg::RADIO_LOCKED);
        $display("test transmit with lead code %0d done", code);
    endtask

    initial begin
        rst = 1'b1;
        basic_mode = 1'b1;
        frame_end = 1'b0;
        fe_route_en = 1'b0;
        gain_tgt = 2'h0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        check(radio_state, tx_ramp_pkg::RADIO_IDLE);
        check(tx_power_word, 5'h00);
        host.rd_reg(tx_ramp_pkg::ADDR_TX_POWER, d);
        check(d, 8'h60);
        host.rd_reg(tx_ramp_pkg::ADDR_TX_PATH, d);
        check(d, 8'h31);
        host.wr_reg(6'h07, 8'hFF);
        host.rd_reg(6'h07, d);
        check(d, 8'h00);
        host.rd_reg(tx_ramp_pkg::ADDR_TX_POWER, d);
        check(d, 8'h60);
        host.wr_reg(tx_ramp_pkg::ADDR_TX_POWER, 8'h85);
        @(negedge core_clk);
        check(amp_high_power, 1'b1);
        check(tx_power_word, 5'h05);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            host.wr_reg(tx_ramp_pkg::ADDR_TX_POWER, {3'h0, pw_w[i]});
            host.wr_reg(tx_ramp_pkg::ADDR_TX_PATH, {6'h0C, pw_o[i]});
            @(negedge core_clk);
            check(tx_power_word, pw_e[i]);
        end
        check(amp_high_power, 1'b0);
        $display("test power word done");
        host.send_cmd(tx_ramp_pkg::CMD_TX_GO);
        check(radio_state, tx_ramp_pkg::RADIO_IDLE);
        host.send_cmd(tx_ramp_pkg::CMD_ARET);
        check(radio_state, tx_ramp_pkg::RADIO_ARET);
        host.send_cmd(tx_ramp_pkg::CMD_LOCK);
        check(radio_state, tx_ramp_pkg::RADIO_LOCKED);
        basic_mode = 1'b0;
        host.send_cmd(tx_ramp_pkg::CMD_TX_GO);
        repeat (3) @(negedge core_clk);
        check(amp_ctrl.synth_tx_en, 1'b0);
        check(radio_state, tx_ramp_pkg::RADIO_LOCKED);
        basic_mode = 1'b1;
        $display("test start refusal done");
        run_tx(2'h0, 2'h2);
        run_tx(2'h1, 2'h3);
        run_tx(2'h2, 2'h1);
        run_tx(2'h3, 2'h3);
        finish_test();
    end
endmodule
